// ---- logic/sps_core.v ----
`timescale 1ns/100ps
`include "sps_defines.vh"

// Overview of operation
// R1 - even parity: data bits plus parity bit hold an even count of ones
// R2 - odd parity: data bits plus parity bit hold an odd count of ones
// R3 - with parity on, transmitted top data bit is replaced by parity
// R4 - with parity on, receive mismatch sets parity flag, may interrupt
// R5 - wait mode changes nothing; enabled interrupt wakes processor from wait
// R6 - halt freezes all registers and stops transmit and receive
// R7 - no event from this block ends halt, only wait
// R8 - all events share one request, gated by enable and global mask
// R9 - enables pair: tx-empty, done, rx-full/overrun, idle, parity, header
// R10 - bit 7 set on holding-to-shift move; cleared by status then write
// R11 - bit 6 set when data character ends; cleared by status then write
// R12 - bit 5 set on receive transfer; cleared by status then data read
// R13 - bit 4 set on idle; rearmed only after next receive-full
// R14 - bit 3 set on word ready while full; held word kept
// R15 - bit 2 set on noise; no own interrupt; status then read clears
// R16 - bit 1 set on framing fault or break; status then read clears
// R17 - framing plus overrun: only overrun flag is set
// R18 - bit 0 set on parity mismatch; cleared by status read then data access
// R19 - status resets to C0h
// R20 - word length 0: 8 data bits; 1: 9 data bits
// R21 - parity enable turns generation and checking on or off
// R22 - clear sequence only clears flags seen set at status access
// R23 - software reads received data before next character completes
module sps_core #(
    parameter BIT_CYC   = `SPS_BIT_CYC,
    parameter IDLE_BITS = `SPS_IDLE_BITS
) (
    // clock and reset
    input  wire       CLK,
    input  wire       RST_N,
    // register port
    input  wire [2:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    output reg  [7:0] RDATA,
    // processor state
    input  wire       GLOBAL_MASK,
    input  wire       WAIT_MODE,
    input  wire       HALT_MODE,
    // serial line
    input  wire       RXD,
    output reg        TXD,
    // interrupt and wake
    output wire       IRQ,
    output wire       WAIT_WAKE
);

    localparam CW = 16;
    localparam [CW-1:0] BIT_N  = BIT_CYC[CW-1:0];
    localparam [CW-1:0] HALF_N = BIT_N >> 1;

    // tx states
    localparam [2:0] TX_IDLE = 3'b001;
    localparam [2:0] TX_LOAD = 3'b010;
    localparam [2:0] TX_SEND = 3'b100;
    // rx states
    localparam [2:0] RX_IDLE = 3'b001;
    localparam [2:0] RX_BITS = 3'b010;
    localparam [2:0] RX_DONE = 3'b100;

    // ----------------------------------------
    // parity
    // ----------------------------------------
    // parity over low 7 or 8 data bits
    function par_bit;
        input [8:0] d;
        input       wlen;
        input       odd;
        begin
            par_bit = (wlen ? ^d[7:0] : ^d[6:0]) ^ odd; // R1 R2
        end
    endfunction

    // ----------------------------------------
    // registers and bus
    // ----------------------------------------
    reg [7:0]  status_q;
    reg [7:0]  ctrl1_q;
    reg [7:0]  ctrl2_q;
    reg        hdr_flag_q;
    reg        hdr_ie_q;
    reg        sync_err_q;
    reg [8:0]  tx_hold_q;
    reg [8:0]  rx_hold_q;
    reg [7:0]  armed_q;
    reg        idle_armed_q;

    wire run         = ~HALT_MODE; // R6
    wire wr_act      = WR & run;
    wire rd_act      = RD & run;
    wire st_acc      = (wr_act | rd_act) & (ADDR == `SPS_ADDR_STATUS);
    wire st_rd       = rd_act & (ADDR == `SPS_ADDR_STATUS);
    wire data_wr     = wr_act & (ADDR == `SPS_ADDR_DATA);
    wire data_rd     = rd_act & (ADDR == `SPS_ADDR_DATA);
    wire wlen        = ctrl1_q[`SPS_C1_WLEN];
    wire parity_enable         = ctrl1_q[`SPS_C1_PCE];
    wire podd        = ctrl1_q[`SPS_C1_PODD];

    // event strobes from the line engines
    reg        ev_txe;
    reg        ev_txd;
    reg        ev_rxdone;
    reg        ev_idle;
    reg        ev_noise;
    reg        ev_frame;
    reg        ev_par;
    reg [8:0]  rx_word;

    wire rx_ovr   = ev_rxdone & status_q[`SPS_ST_RXF];   // R14
    wire rx_xfer  = ev_rxdone & ~status_q[`SPS_ST_RXF];

    // clear masks from status-then-data sequence;
    // any data access ends the arming, so stale flags survive
    reg [7:0] clr;
    always @* begin
        clr = 8'h00;
        if (data_wr) begin
            clr[`SPS_ST_TXE] = armed_q[`SPS_ST_TXE]; // R10 R22
            clr[`SPS_ST_TXD] = armed_q[`SPS_ST_TXD]; // R11
        end
        if (data_rd) begin
            clr[5:1] = armed_q[5:1];                 // R12 R13 R14 R15 R16
        end
        if (data_wr | data_rd) begin
            clr[`SPS_ST_PAR] = armed_q[`SPS_ST_PAR]; // R18
        end
    end

    // set wins over clear in every bit
    reg [7:0] set;
    always @* begin
        set = 8'h00;
        set[`SPS_ST_TXE]   = ev_txe;                                // R10
        set[`SPS_ST_TXD]   = ev_txd;                                // R11
        set[`SPS_ST_RXF]   = rx_xfer;                               // R12
        set[`SPS_ST_IDLE]  = ev_idle & idle_armed_q;                // R13
        set[`SPS_ST_OVR]   = rx_ovr;                                // R14
        set[`SPS_ST_NOISE] = rx_xfer & ev_noise;                    // R15
        set[`SPS_ST_FRAME] = rx_xfer & ev_frame;                    // R16 R17
        set[`SPS_ST_PAR]   = rx_xfer & ev_par & parity_enable;                // R4 R21
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            status_q     <= `SPS_STATUS_RST;                        // R19
            ctrl1_q      <= `SPS_C1_RST;
            ctrl2_q      <= `SPS_C2_RST;
            hdr_flag_q   <= 1'b0;
            hdr_ie_q     <= 1'b0;
            sync_err_q   <= 1'b0;
            tx_hold_q    <= 9'h000;
            rx_hold_q    <= 9'h000;
            armed_q      <= 8'h00;
            idle_armed_q <= 1'b1;
            RDATA        <= 8'h00;
        end else if (run) begin                                     // R6 R5
            status_q <= (status_q & ~clr) | set;
            // only flags seen at a status access are armed for clearing
            if (st_acc)
                armed_q <= status_q;                                // R22
            else if (data_wr | data_rd)
                armed_q <= 8'h00;
            if (st_rd)
                armed_q[`SPS_ST_PAR] <= status_q[`SPS_ST_PAR];      // R18
            else if (st_acc)
                armed_q[`SPS_ST_PAR] <= 1'b0;
            if (rx_xfer)
                idle_armed_q <= 1'b1;                               // R13
            else if (set[`SPS_ST_IDLE])
                idle_armed_q <= 1'b0;
            if (rx_xfer) begin
                rx_hold_q <= rx_word;                               // R14
                ctrl1_q[`SPS_C1_R8] <= rx_word[8];
            end
            if (data_wr)
                tx_hold_q <= {ctrl1_q[`SPS_C1_T8], WDATA};
            if (wr_act && ADDR == `SPS_ADDR_CTRL1)
                ctrl1_q <= {ctrl1_q[`SPS_C1_R8], WDATA[6:0]};
            if (wr_act && ADDR == `SPS_ADDR_CTRL2)
                ctrl2_q <= WDATA;
            if (wr_act && ADDR == `SPS_ADDR_EXT)
                hdr_ie_q <= WDATA[`SPS_EX_HIE];
            // header and sync-error detection are outside this block
            hdr_flag_q <= hdr_flag_q & ~(wr_act && ADDR == `SPS_ADDR_EXT
                          && WDATA[`SPS_EX_HDR]);
            sync_err_q <= sync_err_q;
            case (ADDR)
                `SPS_ADDR_STATUS: RDATA <= status_q;
                `SPS_ADDR_DATA:   RDATA <= rx_hold_q[7:0];
                `SPS_ADDR_CTRL1:  RDATA <= ctrl1_q;
                `SPS_ADDR_CTRL2:  RDATA <= ctrl2_q;
                `SPS_ADDR_EXT:    RDATA <= {5'h00, sync_err_q, hdr_ie_q, hdr_flag_q};
                default:          RDATA <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    wire [5:0] src = {
        status_q[`SPS_ST_TXE]  & ctrl2_q[`SPS_C2_TIE],
        status_q[`SPS_ST_TXD]  & ctrl2_q[`SPS_C2_TX_DONE_IRQ_EN],
        (status_q[`SPS_ST_RXF] | status_q[`SPS_ST_OVR] | sync_err_q)
                               & ctrl2_q[`SPS_C2_RIE],
        status_q[`SPS_ST_IDLE] & ctrl2_q[`SPS_C2_QUIET_LINE_IRQ_EN],
        status_q[`SPS_ST_PAR]  & ctrl1_q[`SPS_C1_PIE],
        hdr_flag_q & hdr_ie_q};                                     // R9
    assign IRQ       = (|src) & ~GLOBAL_MASK;                      // R8
    // halt never woken from here
    assign WAIT_WAKE = IRQ & WAIT_MODE & ~HALT_MODE;               // R5 R7

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    reg [2:0]   tx_st_q;
    reg [CW-1:0] tx_cnt_q;
    reg [3:0]   tx_bit_q;
    reg [10:0]  tx_sh_q;
    // a word written mid-frame is flagged here until the line frees
    reg         tx_pend_q;
    wire [3:0]  nbits = wlen ? 4'hB : 4'hA;                        // R20

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_st_q  <= TX_IDLE;
            tx_cnt_q <= {CW{1'b0}};
            tx_bit_q <= 4'h0;
            tx_sh_q  <= 11'h7FF;
            tx_pend_q <= 1'b0;
            TXD      <= 1'b1;
            ev_txe   <= 1'b0;
            ev_txd   <= 1'b0;
        end else if (run) begin
            ev_txe <= 1'b0;
            ev_txd <= 1'b0;
            case (tx_st_q)
                TX_IDLE: begin
                    if (data_wr || tx_pend_q)
                        tx_st_q <= TX_LOAD;
                end
                TX_LOAD: begin
                    // parity takes the top data bit's place
                    if (wlen)
                        tx_sh_q <= {1'b1, parity_enable ? par_bit(tx_hold_q, 1'b1, podd)
                                    : tx_hold_q[8], tx_hold_q[7:0], 1'b0}; // R3
                    else
                        tx_sh_q <= {2'b11, parity_enable ? par_bit(tx_hold_q, 1'b0, podd)
                                    : tx_hold_q[7], tx_hold_q[6:0], 1'b0}; // R3
                    ev_txe   <= 1'b1;                                // R10
                    tx_bit_q <= 4'h0;
                    tx_cnt_q <= {CW{1'b0}};
                    tx_st_q  <= TX_SEND;
                end
                TX_SEND: begin
                    TXD <= tx_sh_q[0];
                    if (tx_cnt_q == BIT_N - 1'b1) begin
                        tx_cnt_q <= {CW{1'b0}};
                        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                        if (tx_bit_q == nbits - 1'b1) begin
                            ev_txd  <= 1'b1;                         // R11
                            tx_st_q <= TX_IDLE;
                        end else begin
                            tx_bit_q <= tx_bit_q + 4'h1;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 1'b1;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
            // a fresh write wins over the load that empties the holder
            if (data_wr)
                tx_pend_q <= 1'b1;                                   // R10
            else if (tx_st_q == TX_LOAD)
                tx_pend_q <= 1'b0;
            if (tx_st_q == TX_IDLE)
                TXD <= 1'b1;
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    reg [2:0]    rx_st_q;
    reg [CW-1:0] rx_cnt_q;
    reg [3:0]    rx_bit_q;
    reg [9:0]    rx_sh_q;
    reg [7:0]    idle_cnt_q;
    reg [CW-1:0] idle_sub_q;
    reg          rx_prev_q;

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_st_q    <= RX_IDLE;
            rx_cnt_q   <= {CW{1'b0}};
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 10'h000;
            idle_cnt_q <= 8'h00;
            idle_sub_q <= {CW{1'b0}};
            rx_prev_q  <= 1'b1;
            ev_rxdone  <= 1'b0;
            ev_idle    <= 1'b0;
            ev_noise   <= 1'b0;
            ev_frame   <= 1'b0;
            ev_par     <= 1'b0;
            rx_word    <= 9'h000;
        end else if (run) begin
            ev_rxdone <= 1'b0;
            ev_idle   <= 1'b0;
            rx_prev_q <= RXD;
            case (rx_st_q)
                RX_IDLE: begin
                    ev_noise <= 1'b0;
                    if (!RXD) begin
                        rx_cnt_q <= {CW{1'b0}};
                        rx_bit_q <= 4'h0;
                        rx_st_q  <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    // a level change mid-bit counts as noise
                    if (rx_cnt_q == HALF_N && RXD != rx_prev_q)
                        ev_noise <= 1'b1;
                    if (rx_cnt_q == HALF_N) begin
                        rx_sh_q <= {RXD, rx_sh_q[9:1]};
                        if (rx_bit_q == 4'h0 && RXD)
                            rx_st_q <= RX_IDLE;
                        else if (rx_bit_q == nbits - 1'b1)
                            rx_st_q <= RX_DONE;
                        rx_bit_q <= rx_bit_q + 4'h1;
                    end
                    rx_cnt_q <= (rx_cnt_q == BIT_N - 1'b1) ? {CW{1'b0}}
                                : rx_cnt_q + 1'b1;
                end
                RX_DONE: begin
                    // short frame: start bit still sits in [0], data in [8:1]
                    rx_word   <= wlen ? rx_sh_q[8:0] : {1'b0, rx_sh_q[8:1]};
                    ev_frame  <= wlen ? ~rx_sh_q[9] : ~rx_sh_q[9];   // R16
                    ev_par    <= wlen ? (par_bit(rx_sh_q[8:0], 1'b1, podd) != rx_sh_q[8])
                                 : (par_bit({1'b0, rx_sh_q[8:1]}, 1'b0, podd)
                                    != rx_sh_q[8]);                  // R4
                    ev_rxdone <= 1'b1;
                    rx_st_q   <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
            // ----------------------------------------
            // idle line detector
            // ----------------------------------------
            // idle line: IDLE_BITS bit times of ones, a full frame only at 8-bit word length
            if (rx_st_q != RX_IDLE || !RXD) begin
                idle_cnt_q <= 8'h00;
                idle_sub_q <= {CW{1'b0}};
            end else if (idle_cnt_q != IDLE_BITS[7:0]) begin
                if (idle_sub_q == BIT_N - 1'b1) begin
                    idle_sub_q <= {CW{1'b0}};
                    idle_cnt_q <= idle_cnt_q + 8'h01;
                    ev_idle    <= (idle_cnt_q == IDLE_BITS[7:0] - 8'h01); // R13
                end else begin
                    idle_sub_q <= idle_sub_q + 1'b1;
                end
            end
        end
    end

endmodule // sps_core

// ---- logic/sps_defines.vh ----
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// register addresses (chosen)
`define SPS_ADDR_STATUS   3'h0
`define SPS_ADDR_DATA     3'h1
`define SPS_ADDR_CTRL1    3'h2
`define SPS_ADDR_CTRL2    3'h3
`define SPS_ADDR_EXT      3'h4

// status bit positions
`define SPS_ST_TXE        7
`define SPS_ST_TXD        6
`define SPS_ST_RXF        5
`define SPS_ST_IDLE       4
`define SPS_ST_OVR        3
`define SPS_ST_NOISE      2
`define SPS_ST_FRAME      1
`define SPS_ST_PAR        0
`define SPS_STATUS_RST    8'hC0

// ctrl_one bit positions
`define SPS_C1_R8         7
`define SPS_C1_T8         6
`define SPS_C1_WLEN       4
`define SPS_C1_PCE        2
`define SPS_C1_PODD       1
`define SPS_C1_PIE        0
`define SPS_C1_RST        8'h00

// ctrl_two bit positions
`define SPS_C2_TIE        7
`define SPS_C2_TX_DONE_IRQ_EN       6
`define SPS_C2_RIE        5
`define SPS_C2_QUIET_LINE_IRQ_EN       4
`define SPS_C2_RST        8'h00

// extension register: header flag/enable, sync error
`define SPS_EX_HDR        0
`define SPS_EX_HIE        1
`define SPS_EX_SYNC       2

// link timing
`define SPS_BAUD          115200
`define SPS_CLK_HZ        50000000
`define SPS_BIT_CYC       (`SPS_CLK_HZ / `SPS_BAUD)
`define SPS_IDLE_BITS     10

`endif

// ---- verif/sps_core_bench.sv ----
`timescale 1ns/100ps
`include "sps_defines.vh"
module sps_core_bench;
    localparam BC = 4;
    reg        clk, rst_n, wr, rd, gmask, waitm, halt, send;
    reg  [2:0] addr;
    reg  [7:0] wdata, v;
    reg  [9:0] frame;
    reg  [31:0] seed;
    wire [7:0] rdata;
    wire [9:0] got;
    wire       rxd, txd, irq, wake;
    integer    error_cnt, checks_done, k;
    sps_core #(.BIT_CYC(BC)) i_sps_core (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .GLOBAL_MASK(gmask),
        .WAIT_MODE(waitm), .HALT_MODE(halt), .RXD(rxd), .TXD(txd), .IRQ(irq),
        .WAIT_WAKE(wake));
    sps_node #(.BIT_CYC(BC)) i_sps_node (.CLK(clk), .TXD(txd), .RXD(rxd),
        .FRAME(frame), .SEND(send), .GOT(got));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function par(input [7:0] d, input o);
        par = ^d[6:0] ^ o;
    endfunction
    task bwr(input [2:0] a, input [7:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task brd(input [2:0] a, output [7:0] d);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 d = rdata;
            @(posedge clk);
        end
    endtask
    task chk(input [9:0] g, input [9:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0t got %h exp %h", $time, g, e);
            end
            @(posedge clk);
        end
    endtask
    task put(input [7:0] d, input p, input s);
        begin
            frame <= {s, p, d[6:0], 1'b0};
            send <= 1'b1;
            @(posedge clk);
            send <= 1'b0;
            repeat (14 * BC) @(posedge clk);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
    initial begin
        {rst_n, wr, rd, gmask, waitm, halt, send} = 7'h00;
        addr = 3'h0;
        wdata = 8'h00;
        frame = 10'h3FF;
        seed = 94410;
        error_cnt = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        brd(`SPS_ADDR_STATUS, v); chk(v, 8'hC0);
        brd(3'h7, v); chk(v, 8'h00);
        $display("reset test done");
        for (k = 0; k < 4; k = k + 1) begin
            seed = xs(seed);
            bwr(`SPS_ADDR_CTRL1, {5'h00, k[1], k[0], 1'b0});
            brd(`SPS_ADDR_STATUS, v);
            bwr(`SPS_ADDR_DATA, seed[7:0]);
            brd(`SPS_ADDR_STATUS, v); chk(v[6], 1'b0);
            repeat (12 * BC) @(posedge clk);
            chk(got, {1'b1, k[1] ? par(seed[7:0], k[0]) : seed[7], seed[6:0], 1'b0});
            brd(`SPS_ADDR_STATUS, v); chk(v[7:6], 2'h3);
        end
        brd(`SPS_ADDR_STATUS, v);
        bwr(`SPS_ADDR_DATA, 8'h55);
        @(posedge clk);
        brd(`SPS_ADDR_STATUS, v);
        bwr(`SPS_ADDR_DATA, 8'hAA);
        brd(`SPS_ADDR_STATUS, v); chk(v[7], 1'b0);
        repeat (25 * BC) @(posedge clk);
        brd(`SPS_ADDR_STATUS, v); chk(v[7], 1'b1);
        $display("transmit test done");
        bwr(`SPS_ADDR_CTRL2, 8'h80);
        #2 chk(irq, 1'b1);
        gmask <= 1'b1;
        #2 chk(irq, 1'b0);
        gmask <= 1'b0;
        waitm <= 1'b1;
        #2 chk(wake, 1'b1);
        halt <= 1'b1;
        #2 chk(wake, 1'b0);
        bwr(`SPS_ADDR_CTRL2, 8'h00);
        put(8'h00, 1'b0, 1'b1);
        halt <= 1'b0;
        waitm <= 1'b0;
        #2 chk(irq, 1'b1);
        brd(`SPS_ADDR_STATUS, v); chk(v[5], 1'b0);
        bwr(`SPS_ADDR_CTRL2, 8'h00);
        $display("power test done");
        for (k = 0; k < 4; k = k + 1) begin
            seed = xs(seed);
            bwr(`SPS_ADDR_CTRL1, {5'h00, 1'b1, k[0], 1'b1});
            put(seed[7:0], par(seed[7:0], k[0]) ^ k[1], 1'b1);
            #2 chk(irq, k[1]);
            brd(`SPS_ADDR_STATUS, v); chk({v[5], v[0]}, {1'b1, k[1]});
            brd(`SPS_ADDR_DATA, v); chk(v[6:0], seed[6:0]);
            brd(`SPS_ADDR_STATUS, v); chk({v[5], v[0]}, 2'h0);
        end
        repeat (30 * BC) @(posedge clk);
        brd(`SPS_ADDR_STATUS, v); chk(v[4], 1'b1);
        brd(`SPS_ADDR_DATA, v);
        repeat (30 * BC) @(posedge clk);
        brd(`SPS_ADDR_STATUS, v); chk(v[4], 1'b0);
        $display("parity test done");
        bwr(`SPS_ADDR_CTRL1, 8'h00);
        seed = xs(seed);
        put(seed[7:0], seed[7], 1'b1);
        put(~seed[7:0], ~seed[7], 1'b0);
        bwr(`SPS_ADDR_CTRL2, 8'h20);
        #2 chk(irq, 1'b1);
        brd(`SPS_ADDR_STATUS, v); chk({v[5], v[3], v[1]}, 3'h6);
        brd(`SPS_ADDR_DATA, v); chk(v, seed[7:0]);
        put(8'h00, 1'b0, 1'b0);
        brd(`SPS_ADDR_STATUS, v); chk(v[1], 1'b1);
        brd(`SPS_ADDR_DATA, v);
        $display("overrun test done");
        tally_and_finish;
    end
endmodule // sps_core_bench

// ---- verif/sps_core_sva.sv ----
`timescale 1ns/100ps
`include "sps_defines.vh"
module sps_core_sva #(
    parameter BIT_CYC = 4
) (
    input wire       CLK,
    input wire       RST_N,
    input wire [2:0] ADDR,
    input wire [7:0] WDATA,
    input wire       WR,
    input wire       RD,
    input wire [7:0] RDATA,
    input wire       GLOBAL_MASK,
    input wire       WAIT_MODE,
    input wire       HALT_MODE,
    input wire       RXD,
    input wire       TXD,
    input wire       IRQ,
    input wire       WAIT_WAKE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    reg  [5:0]  en_q;
    reg  [15:0] low_q;
    reg  [15:0] hi_q;
    wire        take = WR && !HALT_MODE;
    // ----------------------------------------
    // mirror of enables, line run lengths
    // ----------------------------------------
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_q  <= 6'h00;
            low_q <= 16'h0000;
            hi_q  <= 16'h0000;
        end else begin
            low_q <= TXD ? 16'h0000 : low_q + 16'h0001;
            hi_q  <= TXD ? hi_q + 16'h0001 : 16'h0000;
            if (take && ADDR == `SPS_ADDR_CTRL1) en_q[4] <= WDATA[`SPS_C1_PIE];
            if (take && ADDR == `SPS_ADDR_CTRL2) en_q[3:0] <= WDATA[7:4];
            if (take && ADDR == `SPS_ADDR_EXT) en_q[5] <= WDATA[`SPS_EX_HIE];
        end
    end
    property p_irq_mask; GLOBAL_MASK |-> !IRQ; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_irq_en; (en_q == 6'h00) |-> !IRQ; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq with no enable");
    property p_wake; (IRQ && WAIT_MODE && !HALT_MODE) |-> WAIT_WAKE; endproperty
    a_wake: assert property (p_wake) else $error("no wake from wait");
    property p_wake_src; WAIT_WAKE |-> (IRQ && WAIT_MODE); endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake without cause");
    property p_halt_wake; HALT_MODE |-> !WAIT_WAKE; endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("wake during halt");
    property p_halt_rd; HALT_MODE |=> $stable(RDATA); endproperty
    a_halt_rd: assert property (p_halt_rd) else $error("read data moved in halt");
    property p_halt_tx; HALT_MODE |=> $stable(TXD); endproperty
    a_halt_tx: assert property (p_halt_tx) else $error("line moved in halt");
    property p_halt_irq;
        (HALT_MODE && $past(HALT_MODE) && $stable(GLOBAL_MASK)) |-> $stable(IRQ);
    endproperty
    a_halt_irq: assert property (p_halt_irq) else $error("flags moved in halt");
    property p_tx_start;
        (take && ADDR == `SPS_ADDR_DATA && hi_q > 11 * BIT_CYC) |-> ##[1:3] !TXD;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_bit_time; (TXD && low_q != 16'h0000) |-> (low_q % BIT_CYC) == 0; endproperty
    a_bit_time: assert property (p_bit_time) else $error("bad bit length");
    c_irq: cover property ($rose(IRQ));
    c_wake: cover property (WAIT_WAKE);
    c_halt: cover property (HALT_MODE && IRQ);
endmodule // sps_core_sva

bind sps_core sps_core_sva #(.BIT_CYC(BIT_CYC)) i_sps_core_sva (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .GLOBAL_MASK(GLOBAL_MASK), .WAIT_MODE(WAIT_MODE),
    .HALT_MODE(HALT_MODE), .RXD(RXD), .TXD(TXD), .IRQ(IRQ), .WAIT_WAKE(WAIT_WAKE));

// ---- verif/sps_node.sv ----
`timescale 1ns/100ps
module sps_node #(
    parameter BIT_CYC = 4
) (
    // line side
    input  wire       CLK,
    input  wire       TXD,
    output reg        RXD,
    // bench side
    input  wire [9:0] FRAME,
    input  wire       SEND,
    output reg  [9:0] GOT
);
    // ----------------------------------------
    // remote node, ten bit frames, lsb first
    // ----------------------------------------
    initial RXD = 1'b1;
    always @(posedge CLK) begin : tx
        integer i;
        if (SEND) begin
            for (i = 0; i < 10; i = i + 1) begin
                RXD <= FRAME[i];
                repeat (BIT_CYC) @(posedge CLK);
            end
            RXD <= 1'b1;
        end
    end
    // sample mid bit; later edges ignored while busy
    always @(negedge TXD) begin : rx
        integer j;
        repeat (BIT_CYC / 2) @(posedge CLK);
        for (j = 0; j < 10; j = j + 1) begin
            GOT[j] = TXD;
            repeat (BIT_CYC) @(posedge CLK);
        end
    end
endmodule // sps_node
